// *** nand_host_cfg.svh ***
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH
// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_STAT 8'h0c
`define OFS_RDATA 8'h10
`define OFS_COL 8'h14
// Control register fields
`define CTRL_OP_LSB 0
`define CTRL_GO_BIT 4
`define CTRL_WP_BIT 8
`define CTRL_CE_BIT 9
// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_RB_BIT 1
`define STAT_RVALID_BIT 2
`define STAT_WREQ_BIT 3
`define STAT_DONE_BIT 4
// Opcodes
`define OPC_READ 8'h00
`define OPC_READ_CONF 8'h30
`define OPC_RDO 8'h05
`define OPC_RDO_CONF 8'he0
`define OPC_STATUS 8'h70
`define OPC_RESET 8'hff
`define OPC_PROG 8'h80
`define OPC_PROG_CONF 8'h10
`define OPC_ERASE 8'h60
`define OPC_ERASE_CONF 8'hd0
// Strobe phase timing: 16 ns half period at 125 MHz
`define STROBE_NS 16
`define CLK_NS 8
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// *** nand_host_pkg.sv ***
package nand_host_pkg;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_READ = 3'b001,
		OP_RDO = 3'b010,
		OP_STATUS = 3'b011,
		OP_RESET = 3'b100,
		OP_PROG = 3'b101,
		OP_ERASE = 3'b110
	} op_e;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
	} nand_ctl_s;
	typedef struct packed {
		logic [7:0] dout;
		logic oe;
	} nand_io_s;
endpackage : nand_host_pkg

// *** nand_host.sv ***
// Operation
// - Command latched on write strobe rise with command qualifier held high.
// - Address latched on write strobe rise with address qualifier high.
// - Bits 12-17 pick page, bits 18-28 pick block.
// - Host drives unused address bits low in every address cycle.
// - Five address cycles: two column then three row, last holds bit 28.
// - Column-change commands stay inside the selected page.
// - Host never issues opcodes outside the defined set.
// - Page read is 00h, five address cycles, then 30h.
// - Reset FFh accepted while busy, aborts operation.
// - Column change is 05h, two column cycles, then E0h.
// - Status 70h accepted while busy; reads then return status.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "nand_host_cfg.svh"
module nand_host
	import nand_host_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic [7:0] awaddr, // AXI write address
	input wire logic awvalid, // AXI write address valid
	output logic awready, // AXI write address ready
	input wire logic [31:0] wdata, // AXI write data
	input wire logic [3:0] wstrb, // AXI write strobes
	input wire logic wvalid, // AXI write data valid
	output logic wready, // AXI write data ready
	output logic [1:0] bresp, // AXI write response
	output logic bvalid, // AXI write response valid
	input wire logic bready, // AXI write response ready
	input wire logic [7:0] araddr, // AXI read address
	input wire logic arvalid, // AXI read address valid
	output logic arready, // AXI read address ready
	output logic [31:0] rdata, // AXI read data
	output logic [1:0] rresp, // AXI read response
	output logic rvalid, // AXI read data valid
	input wire logic rready, // AXI read data ready
	output nand_ctl_s nand_ctl, // Flash control pins
	output logic [7:0] shared_io_bus_o, // Flash I/O drive value
	output logic shared_io_bus_oe, // Flash I/O drive enable
	input wire logic [7:0] shared_io_bus_i, // Flash I/O sampled value
	input wire logic ready_busy_n // Flash ready/busy, low busy
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_CMD1 = 4'b0001,
		S_ADDR = 4'b0010,
		S_WDAT = 4'b0011,
		S_CMD2 = 4'b0100,
		S_WAIT = 4'b0101,
		S_RDAT = 4'b0110,
		S_STAT = 4'b0111
	} st_e;
	localparam logic [3:0] STROBE_CYC = 4'(`STROBE_CYC);

	st_e st_reg;
	op_e op_reg;
	logic [28:0] addr_reg;
	logic wstb_reg;
	logic wreq_reg;
	logic [7:0] rbyte_reg;
	logic rvalid_reg;
	logic done_reg;
	logic wp_reg;
	logic ce_reg;
	logic [11:0] col_reg;
	logic [2:0] acnt_reg;
	logic [2:0] alast_reg;
	logic [3:0] tcnt_reg;
	logic phase_reg;
	logic [7:0] latch_reg;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic wr_fire, rd_fire, go_pulse, wdat_push, rdat_pop;
	logic tick;
	logic [7:0] addr_byte;
	logic start;
	op_e go_op;
	// AXI write channel capture, either order
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				awready <= 1'b0;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				wready <= 1'b0;
				w_data_reg <= wdata;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (aw_addr_reg == `OFS_CTRL || aw_addr_reg == `OFS_ADDR ||
					aw_addr_reg == `OFS_WDATA) ? 2'b00 : 2'b10;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end
	assign wr_fire = aw_hold && w_hold && !bvalid;
	assign go_pulse = wr_fire && aw_addr_reg == `OFS_CTRL && w_data_reg[`CTRL_GO_BIT] && (&wstrb);
	assign wdat_push = wr_fire && aw_addr_reg == `OFS_WDATA;
	assign go_op = op_e'(w_data_reg[2:0]);
	// busy gate, only reset or status while busy
	assign start = go_pulse && (st_reg == S_IDLE || st_reg == S_WAIT || st_reg == S_RDAT || st_reg == S_STAT) &&
		(go_op == OP_RESET || go_op == OP_STATUS || (ready_busy_n && st_reg != S_WAIT));
	// Control and address registers written by software
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wp_reg <= 1'b0;
			ce_reg <= 1'b0;
			addr_reg <= 29'h0;
		end else if (wr_fire && aw_addr_reg == `OFS_CTRL) begin
			wp_reg <= w_data_reg[`CTRL_WP_BIT];
			ce_reg <= w_data_reg[`CTRL_CE_BIT];
		end else if (wr_fire && aw_addr_reg == `OFS_ADDR) begin
			addr_reg <= w_data_reg[28:0];
		end
	end
	// AXI read channel
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'b00;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= 2'b00;
			unique case (araddr)
				`OFS_CTRL: rdata <= {22'h0, ce_reg, wp_reg, 5'h0, op_reg};
				`OFS_ADDR: rdata <= {3'h0, addr_reg};
				`OFS_STAT: rdata <= {27'h0, done_reg, wreq_reg, rvalid_reg, ready_busy_n, st_reg != S_IDLE};
				`OFS_RDATA: rdata <= {24'h0, rbyte_reg};
				`OFS_COL: rdata <= {20'h0, col_reg};
				default: begin
					rdata <= 32'h0;
					rresp <= 2'b10;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
	assign rd_fire = arvalid && arready;
	assign rdat_pop = rd_fire && araddr == `OFS_RDATA;
	// Strobe phase timer, restarted at each launch and each data strobe
	always_ff @(posedge sys_clk) begin
		if (!rstn || st_reg == S_IDLE || start || (st_reg == S_WDAT && !wstb_reg)) begin
			tcnt_reg <= 4'h0;
		end else if (tick) begin
			tcnt_reg <= 4'h0;
		end else begin
			tcnt_reg <= tcnt_reg + 4'h1;
		end
	end
	assign tick = (tcnt_reg == STROBE_CYC - 4'h1);
	// Address byte selection per cycle, unused bits held low
	// row layout
	always_comb begin
		unique case (acnt_reg)
			3'd0: addr_byte = addr_reg[7:0];
			3'd1: addr_byte = {4'h0, addr_reg[11:8]};
			3'd2: addr_byte = addr_reg[19:12];
			3'd3: addr_byte = addr_reg[27:20];
			default: addr_byte = {7'h00, addr_reg[28]};
		endcase
	end

	// Sequencer: each bus cycle is a low phase then a high phase
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_reg <= S_IDLE;
			op_reg <= OP_NONE;
			phase_reg <= 1'b0;
			acnt_reg <= 3'd0;
			alast_reg <= 3'd0;
			latch_reg <= 8'h00;
			done_reg <= 1'b0;
			wstb_reg <= 1'b0;
		end else if (start) begin
			phase_reg <= 1'b0;
			op_reg <= go_op;
			done_reg <= 1'b0;
			st_reg <= S_CMD1;
			unique case (go_op)
				OP_READ: latch_reg <= `OPC_READ;
				OP_RDO: latch_reg <= `OPC_RDO;
				OP_STATUS: latch_reg <= `OPC_STATUS;
				OP_PROG: latch_reg <= `OPC_PROG;
				OP_ERASE: latch_reg <= `OPC_ERASE;
				default: latch_reg <= `OPC_RESET;
			endcase
			acnt_reg <= (go_op == OP_ERASE) ? 3'd2 : 3'd0;
			alast_reg <= (go_op == OP_RDO) ? 3'd1 : 3'd4;
		end else begin
			unique case (st_reg)
				S_CMD1, S_ADDR, S_CMD2: if (tick) begin
					phase_reg <= !phase_reg;
					if (phase_reg) begin
						if (st_reg == S_CMD1 && (op_reg == OP_RESET)) begin
							st_reg <= S_WAIT;
						end else if (st_reg == S_CMD1 && op_reg == OP_STATUS) begin
							st_reg <= S_STAT;
						end else if (st_reg == S_CMD1) begin
							st_reg <= S_ADDR;
						end else if (st_reg == S_ADDR && acnt_reg != alast_reg) begin
							acnt_reg <= acnt_reg + 3'd1;
						end else if (st_reg == S_ADDR && op_reg == OP_PROG) begin
							st_reg <= S_WDAT;
						end else if (st_reg == S_ADDR) begin
							st_reg <= S_CMD2;
							unique case (op_reg)
								OP_READ: latch_reg <= `OPC_READ_CONF;
								OP_RDO: latch_reg <= `OPC_RDO_CONF;
								default: latch_reg <= `OPC_ERASE_CONF;
							endcase
						end else begin
							st_reg <= (op_reg == OP_RDO) ? S_RDAT : S_WAIT;
						end
					end
				end
				S_WDAT: if (wstb_reg && tick) begin
					phase_reg <= !phase_reg;
					wstb_reg <= !phase_reg;
				end else if (!wstb_reg && wdat_push) begin
					latch_reg <= w_data_reg[7:0];
					wstb_reg <= 1'b1;
				end else if (!wstb_reg && go_pulse) begin
					latch_reg <= `OPC_PROG_CONF;
					st_reg <= S_CMD2;
				end
				S_WAIT: if (tick && ready_busy_n) begin
					st_reg <= (op_reg == OP_READ) ? S_RDAT : S_IDLE;
					done_reg <= 1'b1;
				end
				S_RDAT, S_STAT: if (go_pulse) st_reg <= S_IDLE;
				default: st_reg <= S_IDLE;
			endcase
		end
	end
	// Read strobe cycles on software demand, column tracked
	// byte per strobe
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rbyte_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			col_reg <= 12'h0;
			wreq_reg <= 1'b0;
		end else begin
			if (st_reg == S_CMD2) begin
				col_reg <= addr_reg[11:0];
			end
			if ((st_reg == S_RDAT || st_reg == S_STAT) && tick && !rvalid_reg && !nand_ctl.re_n && !start) begin
				rbyte_reg <= shared_io_bus_i;
				rvalid_reg <= 1'b1;
				col_reg <= col_reg + 12'h1;
			end else if (rdat_pop || start) begin
				rvalid_reg <= 1'b0;
			end
			wreq_reg <= (st_reg == S_WDAT && !wstb_reg);
		end
	end

	// Pin drive from flip-flops
	// command qualifier
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			nand_ctl <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
			shared_io_bus_o <= 8'h00;
			shared_io_bus_oe <= 1'b0;
		end else begin
			nand_ctl.wp_n <= wp_reg;
			nand_ctl.ce_n <= !(ce_reg || st_reg != S_IDLE);
			nand_ctl.cle <= (st_reg == S_CMD1 || st_reg == S_CMD2);
			nand_ctl.ale <= (st_reg == S_ADDR);
			nand_ctl.we_n <= !((st_reg == S_CMD1 || st_reg == S_CMD2 || st_reg == S_ADDR ||
				(st_reg == S_WDAT && wstb_reg)) && !phase_reg);
			nand_ctl.re_n <= !((st_reg == S_RDAT || st_reg == S_STAT) && !rvalid_reg);
			shared_io_bus_oe <= (st_reg == S_CMD1 || st_reg == S_CMD2 || st_reg == S_ADDR || (st_reg == S_WDAT && wstb_reg));
			shared_io_bus_o <= (st_reg == S_ADDR) ? addr_byte : latch_reg;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// rising edge latch, data cycles carry no qualifier
	a_we_qualifier: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(nand_ctl.we_n) |-> !(nand_ctl.cle && nand_ctl.ale) && shared_io_bus_oe)
		else $error("write strobe rose with both qualifiers or an idle bus");
	a_qual_excl: assert property (!(nand_ctl.cle && nand_ctl.ale)) else $error("both qualifiers high");
	a_select_busy: assert property (st_reg != S_IDLE |=> !nand_ctl.ce_n) else $error("select dropped");
	a_guard_pin: assert property (!wp_reg |=> !nand_ctl.wp_n) else $error("guard pin released");
	a_busy_gate: assert property (start && !ready_busy_n |-> go_op == OP_RESET || go_op == OP_STATUS)
		else $error("operation launched while busy");
	a_addr_top_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		nand_ctl.ale && shared_io_bus_oe && acnt_reg == 3'd4 && st_reg == S_ADDR |=> shared_io_bus_o[7:1] == 7'h00)
		else $error("upper row bits not low");
	a_no_read_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
		!nand_ctl.re_n |-> !shared_io_bus_oe)
		else $error("host drives bus during read strobe");
endmodule : nand_host

// *** nand_dev_model.sv ***
`timescale 1ns/1ns
module nand_dev_model
	import nand_host_pkg::*;
#(
	parameter int BUSY_NS = 4000 // Array time, shortened
) (
	input wire nand_ctl_s ctl, // Host control pins
	input wire logic [7:0] io_in, // Resolved bus level
	output logic [7:0] io_out, // Drive value
	output logic io_oe, // Device drives bus
	output logic rb_n // Low while busy
);
	logic [7:0] cmd;
	logic [7:0] dq = 8'h00;
	logic [28:0] ad;
	logic [11:0] col;
	logic [7:0] mem [logic [28:0]];
	logic [7:0] pend [logic [11:0]];
	int ac = 0;
	int zbad = 0;
	int ab = 0;
	int sm = 0;
	time bend = 0;
	always @(posedge ctl.we_n) begin
		if (ctl.cle) begin
			cmd = io_in;
			sm = (io_in == 8'h70);
			ac = (io_in == 8'h60) ? 2 : 0;
			if (io_in == 8'h10 && ctl.wp_n)
				foreach (pend[c]) mem[{ad[28:12], c}] = pend[c];
			if (io_in == 8'h80)
				pend.delete();
			if (io_in == 8'h30 || io_in == 8'h10 || io_in == 8'hd0)
				bend = $time + ((ctl.wp_n || io_in == 8'h30) ? BUSY_NS : 200);
			if (io_in == 8'hff && !rb_n) begin
				ab = 1;
				bend = $time + 80;
			end
		end else if (ctl.ale) begin
			case (ac)
				0: ad[7:0] = io_in;
				1: ad[11:8] = io_in[3:0];
				2: ad[19:12] = io_in;
				3: ad[27:20] = io_in;
				default: ad[28] = io_in[0];
			endcase
			col = ad[11:0];
			if ((ac == 1 && io_in[7:4] != 4'h0) || (ac == 4 && io_in[7:1] != 7'h00))
				zbad++;
			ac++;
		end else begin
			pend[col] = io_in;
			col++;
		end
	end
	// Byte out on strobe fall, column steps outside status mode
	always @(negedge ctl.re_n) begin
		if (sm)
			dq = {ctl.wp_n, rb_n, 6'h00};
		else begin
			dq = mem.exists({ad[28:12], col}) ? mem[{ad[28:12], col}] : ad[19:12] ^ col[7:0];
			col++;
		end
	end
	// Released bus shows inverse of last byte
	assign io_oe = !ctl.ce_n && !ctl.re_n;
	assign io_out = io_oe ? dq : ~dq;
	always #1 rb_n = ($time >= bend);
endmodule : nand_dev_model

// *** nand_host_bench.sv ***
`timescale 1ns/1ns
module nand_host_bench import nand_host_pkg::*;;
	logic sys_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, io_oe, m_oe, rb_n;
	logic [7:0] awaddr, araddr, io_o, m_o, io_i, pd[2];
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [65:0] e, rq[$];
	logic [1:0] bq[$];
	logic [28:0] ad;
	nand_ctl_s ctl;
	int bad_count, n_compared, seed, i;
	nand_host dut (.sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .nand_ctl(ctl), .shared_io_bus_o(io_o), .shared_io_bus_oe(io_oe),
		.shared_io_bus_i(io_i), .ready_busy_n(rb_n));
	nand_dev_model m (.ctl(ctl), .io_in(io_i), .io_out(m_o), .io_oe(m_oe), .rb_n(rb_n));
	// Bus level from whichever party drives
	assign io_i = io_oe ? io_o : m_o;
	always #4 sys_clk = ~sys_clk;
	function automatic logic [7:0] pat(input logic [7:0] r, input logic [11:0] c);
		return r ^ c[7:0];
	endfunction : pat
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		n_compared++;
		if (ex !== sn) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic results;
		$display("Compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic hang;
		bad_count++;
		results();
	endtask : hang
	// Write holds each channel until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge sys_clk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50 && !bvalid; k++) begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (k == 50)
			hang();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] v, input logic [1:0] r);
		int k;
		@(posedge sys_clk);
		rq.push_back({r, mk, v});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50 && !rvalid; k++) begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		rd_v = rdata;
		rready <= 1'b0;
		if (k == 50)
			hang();
	endtask : rd
	// Poll one status bit, bounded
	task automatic waitst(input int b, input logic v);
		int k;
		for (k = 0; k < 300; k++) begin
			rd(8'h0c, 32'h0, 32'h0, 2'b00);
			if (rd_v[b] === v)
				break;
		end
		if (k == 300)
			hang();
	endtask : waitst
	task automatic getb(input logic [7:0] x);
		waitst(2, 1'b1);
		rd(8'h10, 32'hff, {24'h0, x}, 2'b00);
	endtask : getb
	task automatic prog(input logic [31:0] c, input logic [7:0] x);
		int k;
		wr(8'h00, c, 2'b00);
		for (k = 0; k < 2; k++) begin
			waitst(3, 1'b1);
			wr(8'h08, {24'h0, pd[k] ^ x}, 2'b00);
		end
		waitst(3, 1'b1);
		wr(8'h00, c, 2'b00);
		waitst(0, 1'b0);
	endtask : prog
	// Compare each answer with the oldest note
	always @(posedge sys_clk) begin
		if (bvalid && bready)
			chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
		if (rvalid && rready) begin
			e = rq.pop_front();
			chk("rresp", {30'h0, e[65:64]}, {30'h0, rresp});
			chk("rdata", e[31:0], rdata & e[63:32]);
		end
	end
	initial begin
		seed = 99229;
		sys_clk = 1'b0;
		rstn = 1'b0;
		wstrb = 4'hf;
		wdata = 32'h0;
		{awaddr, araddr} = 16'h0000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk("select", 32'h1, {31'h0, ctl.ce_n});
		chk("guard", 32'h0, {31'h0, ctl.wp_n});
		chk("drive", 32'h0, {31'h0, io_oe});
		wr(8'h40, 32'h0, 2'b10);
		rd(8'h44, 32'h0, 32'h0, 2'b10);
		// Page read at a random row and column
		ad = {17'($random(seed)), 12'($random(seed) & 32'h3ff)};
		wr(8'h04, {3'h0, ad}, 2'b00);
		wr(8'h00, 32'h111, 2'b00);
		for (i = 0; i < 3; i++)
			getb(pat(ad[19:12], 12'(ad[11:0] + i)));
		chk("address", {3'h0, ad}, {3'h0, m.ad});
		// Column change to the last byte of the page
		wr(8'h04, {3'h0, ad[28:12], 12'h83f}, 2'b00);
		wr(8'h00, 32'h112, 2'b00);
		getb(pat(ad[19:12], 12'h83f));
		wr(8'h00, 32'h113, 2'b00);
		getb(8'hc0);
		getb(8'hc0);
		// Program, then a guarded program that must not land
		ad[11:0] = 12'h010;
		pd[0] = 8'($random(seed));
		pd[1] = 8'($random(seed));
		wr(8'h04, {3'h0, ad}, 2'b00);
		prog(32'h115, 8'h00);
		rd(8'h0c, 32'h10, 32'h10, 2'b00);
		prog(32'h015, 8'hff);
		wr(8'h00, 32'h111, 2'b00);
		getb(pd[0]);
		getb(pd[1]);
		// Erase, refused read, status and reset while busy
		wr(8'h00, 32'h116, 2'b00);
		waitst(1, 1'b0);
		wr(8'h00, 32'h111, 2'b00);
		chk("busy guard", 32'hd0, {24'h0, m.cmd});
		wr(8'h00, 32'h113, 2'b00);
		getb(8'h80);
		wr(8'h00, 32'h114, 2'b00);
		waitst(1, 1'b1);
		chk("abort", 32'h1, m.ab);
		chk("zero fill", 32'h0, m.zbad);
		results();
	end
endmodule : nand_host_bench
